// *** hdl/line_monitor_defines.svh ***
// Timing figures and field constants for the line monitor and duty limiter.
// Assumes a single 100 MHz clock; counts are derived here from the figures.
`ifndef LINE_MONITOR_DEFINES_SVH
`define LINE_MONITOR_DEFINES_SVH
`define CLK_MHZ 100
`define STOP_DELAY_US 300
`define HOLD_MS 50
`define START_DELAY_US 100
`define STEP_MS 32
`define FILTER_US 253
`define MIN_OFF_NS 590
`define MAX_DUTY_PCT 78
`define FAST_KHZ 400
`define PEAK_MARGIN 2
`define STOP_DELAY_CYC (`STOP_DELAY_US * `CLK_MHZ)
`define HOLD_CYC (`HOLD_MS * 1000 * `CLK_MHZ)
`define START_DELAY_CYC (`START_DELAY_US * `CLK_MHZ)
`define STEP_CYC (`STEP_MS * 1000 * `CLK_MHZ)
`define FILTER_CYC (`FILTER_US * `CLK_MHZ)
`define MIN_OFF_CYC ((`MIN_OFF_NS * `CLK_MHZ + 999) / 1000)
`define FAST_PERIOD_CYC ((`CLK_MHZ * 1000) / `FAST_KHZ)
`define HIGH_LINE_LEVEL 8
`define SLOPE_SHIFT 2
`endif

// *** hdl/line_monitor_pkg.sv ***
// Types shared by the line monitor top and its peak tracker.
// Assumes nothing beyond a SystemVerilog package-aware compiler.
`default_nettype none
package line_monitor_pkg;
  typedef enum logic [2:0] {
    BO_CHARGE = 3'h0,
    BO_QUALIFY = 3'h1,
    BO_RUN = 3'h2,
    BO_STOP_DLY = 3'h3,
    BO_HOLD = 3'h4,
    BO_BROWNOUT = 3'h5,
    BO_LINE_WAIT = 3'h6
  } bo_state_type;
  typedef enum logic [1:0] {
    PWM_IDLE = 2'h0,
    PWM_ON = 2'h1,
    PWM_OFF = 2'h2
  } pwm_state_type;
  typedef enum logic [1:0] {
    MODE_ACF = 2'h0,
    MODE_TRANSITION = 2'h1,
    MODE_DCM = 2'h2,
    MODE_SKIP = 2'h3
  } mode_type;
  typedef struct packed {
    logic high_line;
    logic [3:0] opp_setting;
    logic [3:0] ilimit_setting;
  } line_select_type;
endpackage
`default_nettype wire

// *** hdl/line_peak_tracker.sv ***
// Quantized line peak tracker: glitch filter, running maximum, held peak.
// Assumes level_in is already synchronised to clk_in and reset is synchronous-released.
`include "line_monitor_defines.svh"
`default_nettype none
module line_peak_tracker #(
  parameter int unsigned LW = 4,
  parameter int unsigned FILTER_CYC = `FILTER_CYC,
  parameter int unsigned STEP_CYC = `STEP_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Quantized level
  input wire logic [LW-1:0] level_in,
  // Peaks
  output logic [LW-1:0] held_out,
  output logic [LW-1:0] cur_out,
  output logic found_out
);
  import line_monitor_pkg::*;
  localparam logic [LW-1:0] TOP = {LW{1'b1}};
  localparam logic [LW-1:0] MARGIN = LW'(`PEAK_MARGIN);
  logic [LW-1:0] cand_reg, filt_reg, max_reg, last_reg, target_reg;
  logic [24:0] fcnt_reg, tick_reg;
  logic falling_reg, evt, tick;
  logic [LW-1:0] new_peak;

  // Saturating add of the peak margin
  function automatic logic [LW-1:0] sat_add(input logic [LW-1:0] a);
    sat_add = (a > TOP - MARGIN) ? TOP : a + MARGIN;
  endfunction

  // Front filter: a level must stand the whole filter time to count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cand_reg <= '0;
      fcnt_reg <= '0;
      filt_reg <= '0;
    end else if (level_in != cand_reg) begin
      cand_reg <= level_in;
      fcnt_reg <= '0;
    end else if (fcnt_reg < 25'(FILTER_CYC - 1)) begin
      fcnt_reg <= fcnt_reg + 25'h1;
    end else begin
      filt_reg <= cand_reg;
    end
  end

  // Peak event once the line falls two levels below the running maximum
  assign evt = !falling_reg && (filt_reg < max_reg) && (max_reg - filt_reg >= MARGIN);
  assign new_peak = sat_add(max_reg);

  // Running maximum; follows the line down after a peak to avoid refiring
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      max_reg <= '0;
      falling_reg <= 1'b0;
    end else if (filt_reg > max_reg) begin
      max_reg <= filt_reg;
      falling_reg <= 1'b0;
    end else if (evt) begin
      max_reg <= filt_reg;
      falling_reg <= 1'b1;
    end else if (falling_reg && filt_reg < max_reg) begin
      max_reg <= filt_reg;
    end
  end

  // Current peak and the two-in-a-row target
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_out <= '0;
      last_reg <= '0;
      target_reg <= '0;
      found_out <= 1'b0;
    end else if (evt) begin
      cur_out <= new_peak;
      last_reg <= new_peak;
      found_out <= 1'b1;
      if (!found_out || new_peak == last_reg) begin
        target_reg <= new_peak;
      end
    end
  end

  // Slew interval divider
  assign tick = (tick_reg == 25'(STEP_CYC - 1));
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick ? 25'h0 : tick_reg + 25'h1;
    end
  end

  // Held peak: first peak taken at once, then one level per interval
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held_out <= '0;
    end else if (evt && !found_out) begin
      held_out <= new_peak;
    end else if (tick && found_out && held_out < target_reg) begin
      held_out <= held_out + LW'(1);
    end else if (tick && found_out && held_out > target_reg) begin
      held_out <= held_out - LW'(1);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  held_step_a: assert property ($past(found_out) && $changed(held_out) |->
      $past(tick) && (held_out == $past(held_out) + LW'(1) ||
      held_out + LW'(1) == $past(held_out)))
    else $error("held peak moved more than one level or off interval");
  peak_margin_a: assert property (evt && max_reg <= TOP - MARGIN |=>
      cur_out == $past(max_reg) + MARGIN)
    else $error("current peak not maximum plus margin");
endmodule
`default_nettype wire

// *** hdl/line_monitor_and_duty_limiter.sv ***
// Brownout filter, line-range selection and main-switch on/off-time limiter.
// Assumes analog comparator pins are asynchronous; mode, sense code, command,
// period and soft-start status come from logic on clk_in.
`include "line_monitor_defines.svh"
`default_nettype none
module line_monitor_and_duty_limiter
  import line_monitor_pkg::*;
#(
  parameter int unsigned NLEV = 15,
  parameter int unsigned PW = 12,
  parameter int unsigned SW = 10,
  parameter int unsigned STOP_CYC = `STOP_DELAY_CYC,
  parameter int unsigned HOLD_CYC = `HOLD_CYC,
  parameter int unsigned START_CYC = `START_DELAY_CYC,
  parameter int unsigned FILTER_CYC = `FILTER_CYC,
  parameter int unsigned STEP_CYC = `STEP_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Analog comparator pins
  input wire logic startup_current_in,
  input wire logic supply_on_in,
  input wire logic line_above_start_in,
  input wire logic line_below_stop_in,
  input wire logic line_present_in,
  input wire logic [NLEV-1:0] line_level_thermo_in,
  // Sequencer status
  input wire logic soft_start_done_in,
  input wire logic ss_wait_done_in,
  input wire line_monitor_pkg::mode_type mode_in,
  // Switching cycle control
  input wire logic cycle_request_in,
  input wire logic [PW-1:0] period_cycles_in,
  input wire logic [PW-1:0] rt_period_cycles_in,
  input wire logic [SW-1:0] current_sense_in,
  input wire logic [SW-1:0] control_command_in,
  // Drive and status
  output logic gate_drive_out,
  output logic run_enable_out,
  output logic brownout_out,
  output logic line_wait_out,
  output var line_monitor_pkg::line_select_type line_select_out
);
  localparam int unsigned NA = NLEV + 5;
  localparam logic [PW-1:0] MIN_OFF = PW'(`MIN_OFF_CYC);
  localparam logic [PW-1:0] FAST_PERIOD = PW'(`FAST_PERIOD_CYC);
  localparam line_select_type SEL_DEFAULT = '{1'b0, 4'h0, 4'h0};

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [NA-1:0] async_vec, sync1_reg, sync2_reg;
  logic startup_on, supply_on, above_start, below_stop, line_present;
  logic [3:0] level;
  bo_state_type bo_state_reg, bo_next;
  logic [25:0] tmr_reg, start_cnt_reg;
  logic start_ok, drive_allow;
  logic line_en_reg;
  logic [3:0] held_peak, cur_peak;
  logic peak_found;
  pwm_state_type pwm_state_reg, pwm_next;
  logic [PW-1:0] cnt_reg, per_reg, onmax_reg, period_eff, on_max, duty_lim;
  logic [PW+6:0] duty_prod;
  logic acf_cyc_reg, trip;
  logic [SW:0] sense_sum;
  logic [PW-1:0] off_cnt_reg;

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Two-flop synchronisers, one per comparator bit
  assign async_vec = {line_level_thermo_in, line_present_in, line_below_stop_in,
                      line_above_start_in, supply_on_in, startup_current_in};
  for (genvar i = 0; i < NA; i++) begin : g_sync
    always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
      end else begin
        sync1_reg[i] <= async_vec[i];
        sync2_reg[i] <= sync1_reg[i];
      end
    end
  end
  assign startup_on = sync2_reg[0];
  assign supply_on = sync2_reg[1];
  assign above_start = sync2_reg[2];
  assign below_stop = sync2_reg[3];
  assign line_present = sync2_reg[4];

  // Thermometer to level index; a popcount tolerates one bad rung
  always_comb begin
    level = 4'h0;
    for (int k = 0; k < NLEV; k++) begin
      level = level + 4'(sync2_reg[k + 5]);
    end
  end

  // Start qualification; held at zero while startup current flows
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      start_cnt_reg <= '0;
    end else if (startup_on || !above_start) begin
      start_cnt_reg <= '0;
    end else if (!start_ok) begin
      start_cnt_reg <= start_cnt_reg + 26'h1;
    end
  end
  assign start_ok = (start_cnt_reg >= 26'(START_CYC - 1));

  // Brownout filter state machine
  always_comb begin
    bo_next = bo_state_reg;
    case (bo_state_reg)
      BO_CHARGE: if (!startup_on && supply_on) bo_next = BO_QUALIFY;
      BO_QUALIFY: begin
        if (startup_on) bo_next = BO_CHARGE;
        else if (start_ok && supply_on) bo_next = BO_RUN;
      end
      BO_RUN: if (below_stop) bo_next = BO_STOP_DLY;
      BO_STOP_DLY: begin
        if (above_start) bo_next = BO_RUN;
        else if (tmr_reg >= 26'(STOP_CYC - 1)) bo_next = BO_HOLD;
      end
      BO_HOLD: begin
        if (start_ok) bo_next = BO_RUN;
        else if (tmr_reg >= 26'(HOLD_CYC - 1)) bo_next = BO_BROWNOUT;
      end
      BO_BROWNOUT: bo_next = BO_QUALIFY;
      BO_LINE_WAIT: if (line_present) bo_next = BO_CHARGE;
      default: bo_next = BO_CHARGE;
    endcase
    if (!line_present && (bo_state_reg == BO_RUN || bo_state_reg == BO_STOP_DLY ||
        bo_state_reg == BO_HOLD)) begin
      bo_next = BO_LINE_WAIT;
    end
  end

  // State register and its dwell timer
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bo_state_reg <= BO_CHARGE;
      tmr_reg <= '0;
    end else begin
      bo_state_reg <= bo_next;
      tmr_reg <= (bo_next != bo_state_reg) ? 26'h0 : tmr_reg + 26'h1;
    end
  end
  assign drive_allow = (bo_state_reg == BO_RUN) || (bo_state_reg == BO_STOP_DLY) ||
                       (bo_state_reg == BO_HOLD);

  // Status flops
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      run_enable_out <= 1'b0;
      brownout_out <= 1'b0;
      line_wait_out <= 1'b0;
    end else begin
      run_enable_out <= drive_allow;
      line_wait_out <= (bo_next == BO_LINE_WAIT);
      if (bo_next == BO_BROWNOUT) brownout_out <= 1'b1;
      else if (bo_next == BO_RUN) brownout_out <= 1'b0;
    end
  end

  line_peak_tracker #(
    .LW(4),
    .FILTER_CYC(FILTER_CYC),
    .STEP_CYC(STEP_CYC)
  ) u_tracker (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .level_in(level),
    .held_out(held_peak),
    .cur_out(cur_peak),
    .found_out(peak_found)
  );

  // Line changes unlocked once soft start and its wait are both over
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      line_en_reg <= 1'b0;
    end else if (soft_start_done_in && ss_wait_done_in) begin
      line_en_reg <= 1'b1;
    end
  end

  // Line-dependent settings; low line until unlocked and a peak exists
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      line_select_out <= SEL_DEFAULT;
    end else if (line_en_reg && peak_found) begin
      line_select_out.high_line <= (held_peak >= 4'(`HIGH_LINE_LEVEL));
      line_select_out.opp_setting <= held_peak;
      line_select_out.ilimit_setting <= cur_peak;
    end
  end

  // Period floor from the timing resistor in active clamp mode
  assign period_eff = (mode_in == MODE_ACF && rt_period_cycles_in > period_cycles_in) ?
                      rt_period_cycles_in : period_cycles_in;
  assign duty_prod = (PW + 7)'(period_eff) * (PW + 7)'(`MAX_DUTY_PCT);
  assign duty_lim = PW'(duty_prod / (PW + 7)'(100));

  // On-time cap: duty ratio when slow, minimum off-time when fast
  always_comb begin
    if (period_eff < FAST_PERIOD) begin
      on_max = (period_eff > MIN_OFF) ? period_eff - MIN_OFF : PW'(1);
    end else begin
      on_max = duty_lim;
    end
    if (mode_in == MODE_ACF && {1'b0, on_max} + {1'b0, MIN_OFF} > {1'b0, period_eff}) begin
      on_max = (period_eff > MIN_OFF) ? period_eff - MIN_OFF : PW'(1);
    end
    if (on_max == '0) on_max = PW'(1);
  end

  // Peak current comparison with a rising compensation ramp
  assign sense_sum = {1'b0, current_sense_in} + (SW + 1)'(cnt_reg >> `SLOPE_SHIFT);
  assign trip = (sense_sum >= {1'b0, control_command_in});

  // Switching cycle sequencer
  always_comb begin
    pwm_next = pwm_state_reg;
    case (pwm_state_reg)
      PWM_IDLE: begin
        if (cycle_request_in && drive_allow && mode_in != MODE_SKIP) begin
          pwm_next = PWM_ON;
        end
      end
      PWM_ON: begin
        if (!drive_allow || trip || cnt_reg >= onmax_reg - PW'(1)) begin
          pwm_next = PWM_OFF;
        end
      end
      PWM_OFF: if (cnt_reg >= per_reg - PW'(1)) pwm_next = PWM_IDLE;
      default: pwm_next = PWM_IDLE;
    endcase
  end

  // Cycle counter with period and cap latched at cycle start
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pwm_state_reg <= PWM_IDLE;
      cnt_reg <= '0;
      per_reg <= '0;
      onmax_reg <= PW'(1);
      acf_cyc_reg <= 1'b0;
    end else begin
      pwm_state_reg <= pwm_next;
      if (pwm_state_reg == PWM_IDLE && pwm_next == PWM_ON) begin
        cnt_reg <= '0;
        per_reg <= period_eff;
        onmax_reg <= on_max;
        acf_cyc_reg <= (mode_in == MODE_ACF);
      end else if (pwm_state_reg != PWM_IDLE) begin
        cnt_reg <= cnt_reg + PW'(1);
      end
    end
  end

  // Gate output; aborting a pulse still finishes the off-time
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gate_drive_out <= 1'b0;
    end else begin
      gate_drive_out <= (pwm_next == PWM_ON) && drive_allow;
    end
  end

  // Off-time counter watched by the minimum off check only
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      off_cnt_reg <= {PW{1'b1}};
    end else if (gate_drive_out) begin
      off_cnt_reg <= '0;
    end else if (off_cnt_reg != {PW{1'b1}}) begin
      off_cnt_reg <= off_cnt_reg + PW'(1);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);
  sequence stop_expired;
    bo_state_reg == BO_STOP_DLY && !above_start && line_present &&
    tmr_reg == 26'(STOP_CYC - 1);
  endsequence
  sequence hold_expired;
    bo_state_reg == BO_HOLD && !start_ok && line_present && tmr_reg == 26'(HOLD_CYC - 1);
  endsequence
  hold_launch_a: assert property (stop_expired |=> bo_state_reg == BO_HOLD)
    else $error("hold timer not launched after stop delay");
  brownout_set_a: assert property (hold_expired |=> brownout_out ##1 !gate_drive_out)
    else $error("brownout not declared at hold expiry");
  hold_cleared_a: assert property (bo_state_reg == BO_HOLD && start_ok && line_present
      |=> bo_state_reg == BO_RUN)
    else $error("hold timer not cleared by start qualification");
  charge_ignored_a: assert property (startup_on |=> start_cnt_reg == 26'h0)
    else $error("line qualified while startup current flows");
  start_cause_a: assert property ($past(bo_state_reg) == BO_QUALIFY && bo_state_reg == BO_RUN
      |-> $past(start_ok) && $past(supply_on) && !$past(startup_on))
    else $error("start without qualification");
  line_freeze_a: assert property (!line_en_reg |=> line_select_out == SEL_DEFAULT)
    else $error("line setting changed before soft start ended");
  removal_stop_a: assert property (!line_present && drive_allow
      |=> line_wait_out ##1 !gate_drive_out)
    else $error("switching not stopped on line removal");
  min_off_a: assert property ($rose(gate_drive_out) && acf_cyc_reg && $past(acf_cyc_reg)
      |-> $past(off_cnt_reg) >= MIN_OFF - PW'(1))
    else $error("minimum off-time violated");
  duty_cap_a: assert property (gate_drive_out |-> cnt_reg <= onmax_reg)
    else $error("on-time beyond cap");
  skip_quiet_a: assert property (mode_in == MODE_SKIP && pwm_state_reg == PWM_IDLE
      |=> !gate_drive_out)
    else $error("pulse issued in skip mode");
endmodule
`default_nettype wire

// *** tb/line_monitor_and_duty_limiter_bench.sv ***
// Self-checking bench for the line monitor and duty limiter.
// Assumes the shortened timing parameters set below; one 100 MHz clock.
`default_nettype none
module line_monitor_and_duty_limiter_bench;
  import line_monitor_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, reset_n_in = 1'b0;
  logic startup_current_in = 1'b1, supply_on_in = 1'b0, line_above_start_in = 1'b0;
  logic line_below_stop_in = 1'b1, line_present_in = 1'b1;
  logic [14:0] line_level_thermo_in = 15'h0;
  logic soft_start_done_in = 1'b0, ss_wait_done_in = 1'b0, cycle_request_in = 1'b0;
  mode_type mode_in = MODE_ACF;
  logic [11:0] period_cycles_in = 12'h0, rt_period_cycles_in = 12'h0;
  logic [9:0] current_sense_in = 10'h0, control_command_in = 10'h3ff;
  logic gate_drive_out, run_enable_out, brownout_out, line_wait_out;
  line_select_type line_select_out;
  int n_fail = 0, n_tests = 0;
  // Short counts keep the run small; expectations use the same values
  line_monitor_and_duty_limiter #(.STOP_CYC(30), .HOLD_CYC(200), .START_CYC(100),
    .FILTER_CYC(5), .STEP_CYC(50)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .startup_current_in(startup_current_in), .supply_on_in(supply_on_in),
    .line_above_start_in(line_above_start_in), .line_below_stop_in(line_below_stop_in),
    .line_present_in(line_present_in), .line_level_thermo_in(line_level_thermo_in),
    .soft_start_done_in(soft_start_done_in), .ss_wait_done_in(ss_wait_done_in),
    .mode_in(mode_in), .cycle_request_in(cycle_request_in),
    .period_cycles_in(period_cycles_in), .rt_period_cycles_in(rt_period_cycles_in),
    .current_sense_in(current_sense_in), .control_command_in(control_command_in),
    .gate_drive_out(gate_drive_out), .run_enable_out(run_enable_out),
    .brownout_out(brownout_out), .line_wait_out(line_wait_out),
    .line_select_out(line_select_out));
  // Free-running clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // Single comparison point, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Advance n edges, landing just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Present a quantized level for a number of cycles
  task automatic lvl(input int n, input int hold);
    line_level_thermo_in = 15'((32'h1 << n) - 1);
    cyc(hold);
  endtask
  // Line above start, not below stop (good) or the reverse
  task automatic line_ok(input logic ok);
    line_above_start_in = ok;
    line_below_stop_in = ~ok;
  endtask
  task automatic wait_run();
    for (int i = 0; i < 200 && run_enable_out !== 1'b1; i++) cyc(1);
  endtask
  // One switching cycle; returns on-time width in clock cycles
  task automatic pulse(input mode_type m, input int per, input int rt, input int sense,
                       input int cmd, output int w);
    mode_in = m;
    period_cycles_in = 12'(per);
    rt_period_cycles_in = 12'(rt);
    current_sense_in = 10'(sense);
    control_command_in = 10'(cmd);
    cycle_request_in = 1'b1;
    w = 0;
    for (int i = 0; i < 10 && gate_drive_out !== 1'b1; i++) cyc(1);
    cycle_request_in = 1'b0;
    for (int i = 0; i < 1000 && gate_drive_out === 1'b1; i++) begin
      w++;
      cyc(1);
    end
    cyc((per > rt ? per : rt) + 5);
  endtask
  task automatic t_startup();
    supply_on_in = 1'b1;
    line_ok(1'b1);
    cyc(150);
    chk(run_enable_out, 1'b0);
    startup_current_in = 1'b0;
    cyc(90);
    chk(run_enable_out, 1'b0);
    wait_run();
    chk(run_enable_out, 1'b1);
    chk(brownout_out, 1'b0);
  endtask
  task automatic t_pwm();
    int w;
    pulse(MODE_DCM, 400, 0, 0, 1023, w);
    chk(w, 312);
    pulse(MODE_ACF, 100, 0, 0, 1023, w);
    chk(w, 41);
    pulse(MODE_DCM, 100, 0, 0, 1023, w);
    chk(w, 41);
    pulse(MODE_ACF, 100, 300, 0, 1023, w);
    chk(w, 234);
    pulse(MODE_TRANSITION, 400, 0, 0, 1023, w);
    chk(w, 312);
    pulse(MODE_ACF, 400, 0, 500, 400, w);
    chk(w <= 2 && w > 0, 1'b1);
    // Ramp alone trips: count over four reaches a command of ten
    pulse(MODE_DCM, 400, 0, 0, 10, w);
    chk(w, 41);
    pulse(MODE_SKIP, 400, 0, 0, 1023, w);
    chk(w, 0);
  endtask
  // Back-to-back active clamp cycles; request held so off-time is the design's own
  task automatic t_burst();
    int w;
    int off;
    mode_in = MODE_ACF;
    period_cycles_in = 12'h064;
    rt_period_cycles_in = 12'h0c8;
    current_sense_in = 10'h000;
    control_command_in = 10'h3ff;
    cycle_request_in = 1'b1;
    w = 0;
    off = 0;
    for (int i = 0; i < 20 && gate_drive_out !== 1'b1; i++) cyc(1);
    for (int i = 0; i < 300 && gate_drive_out === 1'b1; i++) begin
      w++;
      cyc(1);
    end
    for (int i = 0; i < 300 && gate_drive_out !== 1'b1; i++) begin
      off++;
      cyc(1);
    end
    cycle_request_in = 1'b0;
    chk(w, 141);
    chk(off >= 59, 1'b1);
    chk(w + off >= 200, 1'b1);
    cyc(210);
  endtask
  task automatic t_line();
    int prev;
    int steps;
    int last_t;
    lvl(0, 10);
    for (int n = 1; n <= 5; n++) lvl(n, 10);
    lvl(4, 10);
    lvl(3, 20);
    chk(line_select_out, 9'h000);
    soft_start_done_in = 1'b1;
    cyc(10);
    chk(line_select_out, 9'h000);
    ss_wait_done_in = 1'b1;
    cyc(10);
    chk(line_select_out, 9'h077);
    lvl(12, 2);
    lvl(3, 30);
    chk(line_select_out, 9'h077);
    // New peak of 11 seen once: held stays, current follows
    lvl(9, 20);
    lvl(7, 20);
    chk(line_select_out, 9'h07b);
    // Seen twice: held slews up one level per interval
    lvl(9, 20);
    lvl(7, 0);
    prev = 7;
    steps = 0;
    last_t = 0;
    for (int i = 0; i < 300; i++) begin
      cyc(1);
      if (line_select_out.opp_setting != prev) begin
        chk(line_select_out.opp_setting, prev + 1);
        if (steps > 0) chk(i - last_t, 50);
        steps++;
        last_t = i;
        prev = line_select_out.opp_setting;
      end
    end
    chk(steps, 4);
    chk(line_select_out, 9'h1bb);
  endtask
  task automatic t_brownout();
    int lost;
    line_ok(1'b0);
    cyc(60);
    line_ok(1'b1);
    lost = 0;
    // Line back inside the hold window: drive must never drop
    for (int i = 0; i < 250; i++) begin
      cyc(1);
      if (run_enable_out !== 1'b1) lost++;
    end
    chk(lost, 0);
    chk(brownout_out, 1'b0);
    line_ok(1'b0);
    cyc(110);
    chk(run_enable_out, 1'b1);
    // Two sync edges, one state edge, then stop delay and hold timer
    cyc(122);
    chk(brownout_out, 1'b0);
    cyc(1);
    chk(brownout_out, 1'b1);
    cyc(1);
    chk(run_enable_out, 1'b0);
    cycle_request_in = 1'b1;
    cyc(10);
    chk(gate_drive_out, 1'b0);
    cycle_request_in = 1'b0;
  endtask
  task automatic t_removal();
    line_ok(1'b1);
    wait_run();
    chk(brownout_out, 1'b0);
    line_present_in = 1'b0;
    cyc(8);
    chk(line_wait_out, 1'b1);
    chk(run_enable_out, 1'b0);
    line_present_in = 1'b1;
    cyc(8);
    chk(line_wait_out, 1'b0);
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the few thousand cycles expected
  initial begin
    repeat (50000) @(posedge clk_in);
    n_fail++;
    finish_test();
  end
  // Main sequence
  initial begin
    cyc(2);
    chk(line_select_out, 9'h000);
    chk(run_enable_out, 1'b0);
    reset_n_in = 1'b1;
    cyc(4);
    t_startup();
    t_pwm();
    t_burst();
    t_line();
    t_brownout();
    t_removal();
    finish_test();
  end
endmodule
`default_nettype wire
